/* verilog/spcu_pkg.sv */
`default_nettype none
package spcu_pkg;
  localparam int unsigned SPCU_DW = 16;
  localparam logic [15:0] SPCU_ROOT_ADDR = 16'h0000;
  localparam logic [15:0] SPCU_ONE = 16'h0001;
  localparam logic [7:0] SPCU_NULL_NUM = 8'h00;
  localparam logic [6:0] SPCU_NULL_SEG = 7'h00;
  localparam int unsigned SPCU_LEN_SHIFT = 2;
  // Register indices on the plain register port.
  localparam logic [2:0] SPCU_REG_CMD = 3'h0;
  localparam logic [2:0] SPCU_REG_BASE = 3'h1;
  localparam logic [2:0] SPCU_REG_LIMIT = 3'h2;
  localparam logic [2:0] SPCU_REG_PC = 3'h3;
  localparam logic [2:0] SPCU_REG_SEG = 3'h4;
  localparam logic [2:0] SPCU_REG_PCREL = 3'h5;
  typedef enum logic [1:0] {
    SPCU_OP_NONE = 2'h0,
    SPCU_OP_CALL = 2'h1,
    SPCU_OP_EXIT = 2'h2,
    SPCU_OP_LOAD = 2'h3
  } spcu_op_type;
  typedef enum logic [2:0] {
    SPCU_TRAP_NONE = 3'h0,
    SPCU_TRAP_COUNT = 3'h1,
    SPCU_TRAP_UNCALL = 3'h2,
    SPCU_TRAP_ABSENT = 3'h3,
    SPCU_TRAP_NOSEG = 3'h4
  } spcu_trap_type;
  typedef struct packed {
    logic [5:0] rsv;
    spcu_op_type op;
    logic [7:0] arg;
  } spcu_cmd_type;
  typedef struct packed {
    logic absent;
    logic priv;
    logic trace;
    logic refbit;
    logic [11:0] len;
  } spcu_desc_type;
  typedef struct packed {
    logic ext;
    logic uncall;
    logic [5:0] rsv;
    logic [7:0] last;
  } spcu_sttlen_type;
  typedef struct packed {
    logic ext;
    logic uncall;
    logic [13:0] addr;
  } spcu_loc_type;
  typedef struct packed {
    logic ext;
    logic [6:0] seg;
    logic [7:0] ent;
  } spcu_ext_type;
  typedef enum logic [3:0] {
    SPCU_S_IDLE = 4'h0,
    SPCU_S_LEN = 4'h1,
    SPCU_S_LBL = 4'h2,
    SPCU_S_DEC = 4'h3,
    SPCU_S_ROOT = 4'h4,
    SPCU_S_D0 = 4'h5,
    SPCU_S_D1 = 4'h6,
    SPCU_S_XLEN = 4'h7,
    SPCU_S_XLBL = 4'h8,
    SPCU_S_PUSHP = 4'h9,
    SPCU_S_PUSHS = 4'ha,
    SPCU_S_COMMIT = 4'hb
  } spcu_state_type;
endpackage
`default_nettype wire

/* verilog/spcu_call_unit.sv */
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Function
// (RULE_01) Root word at address 0 gives the code segment table start.
// (RULE_02) Each descriptor is two words indexed by segment number.
// (RULE_03) Entry 0 gives table length; segment 0 never exists. The code never reads the length and refuses only segment 0.
// (RULE_04) Code base loads from descriptor second word on entering a segment.
// (RULE_05) Code limit derives from descriptor length; program counter runs base to limit.
// (RULE_06) Transfer entry n is read at code limit minus n.
// (RULE_07) Transfer entry 0 holds last valid number; larger call numbers are refused.
// (RULE_08) Local call number 0 takes its label from the stack top word.
// (RULE_09) External call to entry 0 checks uncallable, then starts at code base.
// (RULE_10) Local label is a positive offset from the current code base.
// (RULE_11) The call pushes the return point before transferring control.
// (RULE_12) Exit resumes right after the calling instruction.
// (RULE_13) Label with top bit set is external: segment and entry number.
// (RULE_14) External label selects descriptor by segment, transfer word by entry.
// (RULE_15) Absent target segment must be brought in before transfer.
// (RULE_16) External call loads base, limit, then base-relative entry address.
// (RULE_17) Descriptor absence flag 1 means segment not resident.
// (RULE_18) Descriptor mode flag 1 runs the segment privileged.
// (RULE_19) Descriptor trace flag 1 invokes the trace routine on call.
// (RULE_20) Uncallable entry forbids external calls made in user mode.
// (RULE_21) Failed checks or absent target trap instead of transferring.
module spcu_call_unit (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [2:0] i_reg_addr,
  input wire logic [spcu_pkg::SPCU_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [spcu_pkg::SPCU_DW-1:0] o_reg_rdata,
  output logic o_mem_rd,
  output logic [spcu_pkg::SPCU_DW-1:0] o_mem_addr,
  input wire logic i_mem_valid,
  input wire logic [spcu_pkg::SPCU_DW-1:0] i_mem_rdata,
  input wire logic [spcu_pkg::SPCU_DW-1:0] i_stack_top,
  input wire logic [spcu_pkg::SPCU_DW-1:0] i_stack_next,
  output logic o_stk_push,
  output logic [spcu_pkg::SPCU_DW-1:0] o_stk_data,
  output logic o_stk_pop,
  output logic o_trap,
  output logic [2:0] o_trap_cause,
  output logic o_trace,
  output logic o_priv,
  output logic o_busy
);
  import spcu_pkg::*;

  spcu_state_type state_ff;
  spcu_op_type op_ff;
  spcu_cmd_type cmd;
  spcu_desc_type desc_ff;
  spcu_desc_type rd_desc;
  spcu_sttlen_type rd_len;
  spcu_loc_type rd_loc;
  spcu_loc_type lbl_loc;
  spcu_ext_type lbl_ext;
  logic [15:0] lbl_ff;
  logic [7:0] num_ff;
  logic [6:0] tseg_ff;
  logic [7:0] tent_ff;
  logic [15:0] tbase_ff;
  logic [15:0] tlim_ff;
  logic [15:0] retrel_ff;
  logic [15:0] newpc_ff;
  logic [15:0] mem_addr_ff;
  logic ext_ff;
  logic [15:0] pb_ff;
  logic [15:0] pl_ff;
  logic [15:0] pc_ff;
  logic [6:0] seg_ff;
  logic priv_ff;
  logic trap_ff;
  logic [2:0] cause_ff;
  logic trace_ff;
  logic push_ff;
  logic pop_ff;
  logic [15:0] stk_data_ff;
  logic [15:0] rdata_ff;
  logic cmd_go;
  logic pc_wr;
  logic [15:0] new_lim;

  // Length counts four-word units, so the limit is the last word of the segment.
  function automatic logic [15:0] seg_limit(input logic [15:0] base,
                                            input logic [11:0] len);
    logic [15:0] words;
    words = 16'(len) << SPCU_LEN_SHIFT;
    seg_limit = base + words - SPCU_ONE;
  endfunction

  // Transfer entries count down from the limit, so entry 0 is the limit word itself.
  function automatic logic [15:0] stt_addr(input logic [15:0] limit, input logic [7:0] num);
    stt_addr = limit - 16'(num);
  endfunction

  // Two words per descriptor, so the segment number is doubled.
  function automatic logic [15:0] desc_addr(input logic [15:0] root, input logic [6:0] seg);
    desc_addr = root + 16'({seg, 1'b0});
  endfunction

  // User mode may not enter an uncallable entry; privileged code still can.
  function automatic logic call_barred(input logic uncall, input logic in_priv);
    call_barred = uncall && !in_priv;
  endfunction

  // Every state that waits on a memory word keeps the read request up.
  function automatic logic is_read(input spcu_state_type s);
    is_read = (s == SPCU_S_LEN) || (s == SPCU_S_LBL) || (s == SPCU_S_ROOT) ||
              (s == SPCU_S_D0) || (s == SPCU_S_D1) || (s == SPCU_S_XLEN) ||
              (s == SPCU_S_XLBL);
  endfunction

  assign cmd = spcu_cmd_type'(i_reg_wdata);
  assign cmd_go = i_reg_wr && (i_reg_addr == SPCU_REG_CMD) && (state_ff == SPCU_S_IDLE);
  assign pc_wr = i_reg_wr && (i_reg_addr == SPCU_REG_PCREL) && (state_ff == SPCU_S_IDLE);
  assign rd_desc = spcu_desc_type'(i_mem_rdata);
  assign rd_len = spcu_sttlen_type'(i_mem_rdata);
  assign rd_loc = spcu_loc_type'(i_mem_rdata);
  assign lbl_loc = spcu_loc_type'(lbl_ff);
  assign lbl_ext = spcu_ext_type'(lbl_ff);
  assign new_lim = seg_limit(i_mem_rdata, desc_ff.len); // RULE_05

  // Sequencer for calls, exits and segment loads.
  // A command that arrives while busy is dropped; software polls o_busy.
  always_ff @(posedge i_clk) begin
    // The trap flag is a pulse: it drops every cycle unless a check fails.
    trap_ff <= 1'b0;
    if (!i_reset_n) begin
      state_ff <= SPCU_S_IDLE;
      op_ff <= SPCU_OP_NONE;
      num_ff <= 8'h00;
      lbl_ff <= 16'h0000;
      tseg_ff <= 7'h00;
      tent_ff <= 8'h00;
      tbase_ff <= 16'h0000;
      tlim_ff <= 16'h0000;
      retrel_ff <= 16'h0000;
      newpc_ff <= 16'h0000;
      mem_addr_ff <= 16'h0000;
      desc_ff <= '0;
      ext_ff <= 1'b0;
      cause_ff <= SPCU_TRAP_NONE;
    end else begin
      unique case (state_ff)
        SPCU_S_IDLE: begin
          if (cmd_go) begin
            op_ff <= cmd.op;
            ext_ff <= 1'b0;
            unique case (cmd.op)
              SPCU_OP_CALL: begin
                num_ff <= cmd.arg;
                if (cmd.arg == SPCU_NULL_NUM) begin
                  lbl_ff <= i_stack_top; // RULE_08
                  state_ff <= SPCU_S_DEC;
                end else begin
                  mem_addr_ff <= pl_ff; // RULE_07
                  state_ff <= SPCU_S_LEN;
                end
              end
              SPCU_OP_EXIT: begin
                tseg_ff <= i_stack_top[6:0]; // RULE_12
                retrel_ff <= i_stack_next;
                mem_addr_ff <= SPCU_ROOT_ADDR;
                state_ff <= SPCU_S_ROOT;
              end
              SPCU_OP_LOAD: begin
                tseg_ff <= cmd.arg[6:0];
                retrel_ff <= 16'h0000;
                mem_addr_ff <= SPCU_ROOT_ADDR; // RULE_01
                state_ff <= SPCU_S_ROOT;
              end
              SPCU_OP_NONE: begin
                state_ff <= SPCU_S_IDLE;
              end
            endcase
          end
        end
        SPCU_S_LEN: begin
          if (i_mem_valid) begin
            if (num_ff > rd_len.last) begin // RULE_07
              trap_ff <= 1'b1; // RULE_21
              cause_ff <= SPCU_TRAP_COUNT;
              state_ff <= SPCU_S_IDLE;
            end else begin
              mem_addr_ff <= stt_addr(pl_ff, num_ff); // RULE_06
              state_ff <= SPCU_S_LBL;
            end
          end
        end
        SPCU_S_LBL: begin
          if (i_mem_valid) begin
            lbl_ff <= i_mem_rdata;
            state_ff <= SPCU_S_DEC;
          end
        end
        // A label taken from the stack skips the count check; later checks still apply.
        SPCU_S_DEC: begin
          if (lbl_ext.ext) begin // RULE_13
            ext_ff <= 1'b1;
            tseg_ff <= lbl_ext.seg; // RULE_14
            tent_ff <= lbl_ext.ent;
            mem_addr_ff <= SPCU_ROOT_ADDR; // RULE_01
            state_ff <= SPCU_S_ROOT;
          end else begin
            newpc_ff <= pb_ff + 16'(lbl_loc.addr); // RULE_10
            state_ff <= SPCU_S_PUSHP;
          end
        end
        SPCU_S_ROOT: begin
          if (i_mem_valid) begin
            if (tseg_ff == SPCU_NULL_SEG) begin // RULE_03
              trap_ff <= 1'b1; // RULE_21
              cause_ff <= SPCU_TRAP_NOSEG;
              state_ff <= SPCU_S_IDLE;
            end else begin
              mem_addr_ff <= desc_addr(i_mem_rdata, tseg_ff); // RULE_02
              state_ff <= SPCU_S_D0;
            end
          end
        end
        SPCU_S_D0: begin
          if (i_mem_valid) begin
            desc_ff <= rd_desc;
            if (rd_desc.absent) begin // RULE_17
              // The operating system brings the segment in, then retries.
              trap_ff <= 1'b1; // RULE_15
              cause_ff <= SPCU_TRAP_ABSENT; // RULE_21
              state_ff <= SPCU_S_IDLE;
            end else begin
              mem_addr_ff <= mem_addr_ff + SPCU_ONE; // RULE_02
              state_ff <= SPCU_S_D1;
            end
          end
        end
        SPCU_S_D1: begin
          if (i_mem_valid) begin
            tbase_ff <= i_mem_rdata; // RULE_04
            tlim_ff <= new_lim; // RULE_05
            if (op_ff == SPCU_OP_CALL) begin
              mem_addr_ff <= new_lim; // RULE_16
              state_ff <= SPCU_S_XLEN;
            end else begin
              newpc_ff <= i_mem_rdata + retrel_ff; // RULE_12
              state_ff <= SPCU_S_COMMIT;
            end
          end
        end
        SPCU_S_XLEN: begin
          if (i_mem_valid) begin
            if (tent_ff > rd_len.last) begin // RULE_07
              trap_ff <= 1'b1; // RULE_21
              cause_ff <= SPCU_TRAP_COUNT;
              state_ff <= SPCU_S_IDLE;
            end else if (tent_ff == SPCU_NULL_NUM) begin
              if (call_barred(rd_len.uncall, priv_ff)) begin // RULE_09
                trap_ff <= 1'b1; // RULE_21
                cause_ff <= SPCU_TRAP_UNCALL;
                state_ff <= SPCU_S_IDLE;
              end else begin
                newpc_ff <= tbase_ff; // RULE_09
                state_ff <= SPCU_S_PUSHP;
              end
            end else begin
              mem_addr_ff <= stt_addr(tlim_ff, tent_ff); // RULE_14
              state_ff <= SPCU_S_XLBL;
            end
          end
        end
        SPCU_S_XLBL: begin
          if (i_mem_valid) begin
            if (call_barred(rd_loc.uncall, priv_ff)) begin // RULE_20
              trap_ff <= 1'b1; // RULE_21
              cause_ff <= SPCU_TRAP_UNCALL;
              state_ff <= SPCU_S_IDLE;
            end else begin
              newpc_ff <= tbase_ff + 16'(rd_loc.addr); // RULE_16
              state_ff <= SPCU_S_PUSHP;
            end
          end
        end
        SPCU_S_PUSHP: begin
          state_ff <= SPCU_S_PUSHS;
        end
        SPCU_S_PUSHS: begin
          state_ff <= SPCU_S_COMMIT;
        end
        // Commit has a cycle of its own so both pushed words are latched before the registers move.
        SPCU_S_COMMIT: begin
          state_ff <= SPCU_S_IDLE;
        end
        default: begin
          state_ff <= SPCU_S_IDLE;
        end
      endcase
    end
  end

  // Architectural registers change only at commit or, for the PC, on a PCREL write in idle, so a trap leaves them intact.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pb_ff <= 16'h0000;
      pl_ff <= 16'h0000;
      pc_ff <= 16'h0000;
      seg_ff <= 7'h00;
      // Come out of reset privileged so start-up code can reach uncallable entries.
      priv_ff <= 1'b1;
    end else if (state_ff == SPCU_S_COMMIT) begin
      pc_ff <= newpc_ff;
      if (op_ff != SPCU_OP_CALL || ext_ff) begin
        pb_ff <= tbase_ff; // RULE_04
        pl_ff <= tlim_ff; // RULE_16
        seg_ff <= tseg_ff;
        priv_ff <= desc_ff.priv; // RULE_18
      end
    end else if (pc_wr) begin
      pc_ff <= pb_ff + i_reg_wdata;
    end
  end

  // Return point is pushed as the caller's base-relative offset, then its segment.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      push_ff <= 1'b0;
      pop_ff <= 1'b0;
      trace_ff <= 1'b0;
      stk_data_ff <= 16'h0000;
    end else begin
      push_ff <= (state_ff == SPCU_S_PUSHP) || (state_ff == SPCU_S_PUSHS); // RULE_11
      // The pop goes out at once, so an exit that later traps has already dropped its words.
      pop_ff <= cmd_go && (cmd.op == SPCU_OP_EXIT);
      trace_ff <= (state_ff == SPCU_S_COMMIT) && (op_ff == SPCU_OP_CALL) &&
                  ext_ff && desc_ff.trace; // RULE_19
      if (state_ff == SPCU_S_PUSHP) begin
        stk_data_ff <= pc_ff - pb_ff + SPCU_ONE; // RULE_11
      end else if (state_ff == SPCU_S_PUSHS) begin
        stk_data_ff <= 16'({seg_ff});
      end
    end
  end

  // Register read port: data stand in the cycle after the read strobe.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdata_ff <= 16'h0000;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        SPCU_REG_CMD: rdata_ff <= {11'h000, priv_ff, o_busy, cause_ff};
        SPCU_REG_BASE: rdata_ff <= pb_ff;
        SPCU_REG_LIMIT: rdata_ff <= pl_ff;
        SPCU_REG_PC: rdata_ff <= pc_ff;
        SPCU_REG_SEG: rdata_ff <= 16'({seg_ff});
        SPCU_REG_PCREL: rdata_ff <= pc_ff - pb_ff;
        default: rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_mem_rd = is_read(state_ff);
  assign o_mem_addr = mem_addr_ff;
  assign o_stk_push = push_ff;
  assign o_stk_data = stk_data_ff;
  assign o_stk_pop = pop_ff;
  assign o_trap = trap_ff;
  assign o_trap_cause = cause_ff;
  assign o_trace = trace_ff;
  assign o_priv = priv_ff;
  assign o_busy = (state_ff != SPCU_S_IDLE);
endmodule // spcu_call_unit
`default_nettype wire

/* bench/spcu_call_unit_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module spcu_call_unit_sva (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_mem_rd,
  input wire logic [15:0] o_mem_addr,
  input wire logic i_mem_valid,
  input wire logic o_stk_push,
  input wire logic o_stk_pop,
  input wire logic o_trap,
  input wire logic [2:0] o_trap_cause,
  input wire logic o_trace,
  input wire logic o_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_rdata_quiet:
    assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000) else $error("stray read data");
  chk_push_pair:
    assert property ($rose(o_stk_push) |=> o_stk_push ##1 !o_stk_push) else $error("push not paired");
  chk_push_after_reads:
    assert property (o_stk_push |-> !o_mem_rd && o_busy) else $error("push during fetch");
  chk_trap_ends_call:
    assert property (o_trap |-> !o_busy && !o_stk_push && !o_trace) else $error("trap transfers");
  chk_trap_has_cause:
    assert property (o_trap |-> o_trap_cause != 3'h0) else $error("trap without cause");
  chk_addr_held:
    assert property (o_mem_rd && !i_mem_valid |=> o_mem_rd && $stable(o_mem_addr))
      else $error("fetch address moved");
  chk_idle_no_fetch:
    assert property (!o_busy |-> !o_mem_rd) else $error("fetch while idle");
  chk_pop_single:
    assert property (o_stk_pop |=> !o_stk_pop && !o_stk_push) else $error("pop repeated");
  chk_busy_bounded:
    assert property ($rose(o_busy) |-> ##[1:120] !o_busy) else $error("call never ends");
  cov_trap: cover property (o_trap);
  cov_trace: cover property (o_trace);
  cov_pop: cover property (o_stk_pop);
endmodule // spcu_call_unit_sva
bind spcu_call_unit spcu_call_unit_sva spcu_call_unit_sva_inst (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem_rd(o_mem_rd),
  .o_mem_addr(o_mem_addr), .i_mem_valid(i_mem_valid), .o_stk_push(o_stk_push),
  .o_stk_pop(o_stk_pop), .o_trap(o_trap), .o_trap_cause(o_trap_cause), .o_trace(o_trace),
  .o_busy(o_busy));
`default_nettype wire

/* bench/spcu_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spcu_mem_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  output logic o_valid,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:65535];
  logic [1:0] wait_ff;
  // Between answers the data lines churn, so a stale word is never mistaken for a fresh one.
  always_ff @(posedge i_clk) begin
    if (i_rd && !o_valid && (wait_ff == 2'h2 || !i_slow)) begin
      o_valid <= 1'b1;
      o_rdata <= mem[i_addr];
      wait_ff <= 2'h0;
    end else begin
      o_valid <= 1'b0;
      o_rdata <= ~o_rdata;
      wait_ff <= (i_rd && !o_valid) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule // spcu_mem_model
`default_nettype wire

/* bench/segmented_procedure_call_unit_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module segmented_procedure_call_unit_tb_top;
  import spcu_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [2:0] i_reg_addr = 3'h0;
  logic [15:0] i_reg_wdata = 16'h0000, i_stack_top = 16'h0000, i_stack_next = 16'h0000;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_slow = 1'b0;
  logic [15:0] o_reg_rdata, o_mem_addr, i_mem_rdata, o_stk_data;
  logic o_mem_rd, i_mem_valid, o_stk_push, o_stk_pop, o_trap, o_trace, o_priv, o_busy;
  logic [2:0] o_trap_cause;
  int fail_count = 0, num_checks = 0, trap_n = 0, trace_n = 0, pop_n = 0;
  logic [15:0] pq [$];
  // Address and word pairs: root, table, four descriptors, two transfer tables.
  logic [31:0] img [18] = '{32'h0000_0100, 32'h0100_0108, 32'h0102_0004, 32'h0103_1000,
    32'h0104_2004, 32'h0105_2000, 32'h0106_8004, 32'h0107_4000, 32'h0108_4004, 32'h0109_3000,
    32'h100f_0004, 32'h100e_0020, 32'h100d_8201, 32'h100c_8301, 32'h100b_8202,
    32'h200f_0002, 32'h200e_0030, 32'h200d_4040};
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  spcu_call_unit spcu_call_unit_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr), .i_mem_valid(i_mem_valid), .i_mem_rdata(i_mem_rdata),
    .i_stack_top(i_stack_top), .i_stack_next(i_stack_next), .o_stk_push(o_stk_push),
    .o_stk_data(o_stk_data), .o_stk_pop(o_stk_pop), .o_trap(o_trap),
    .o_trap_cause(o_trap_cause), .o_trace(o_trace), .o_priv(o_priv), .o_busy(o_busy));
  spcu_mem_model spcu_mem_model_inst (.i_clk(i_clk), .i_slow(i_slow), .i_rd(o_mem_rd),
    .i_addr(o_mem_addr), .o_valid(i_mem_valid), .o_rdata(i_mem_rdata));
  always @(posedge i_clk) begin
    if (o_stk_push === 1'b1) pq.push_back(o_stk_data);
    if (o_trap === 1'b1) trap_n++;
    if (o_trace === 1'b1) trace_n++;
    if (o_stk_pop === 1'b1) pop_n++;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, exp);
  endtask
  // The wait is bounded so a hung sequencer ends the run instead of stalling it.
  task automatic cmd(input spcu_op_type op, input logic [7:0] arg);
    int n;
    wr(SPCU_REG_CMD, {6'h00, op, arg});
    #1;
    for (n = 0; n < 200 && o_busy !== 1'b0; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (o_busy !== 1'b0) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic pushed(input logic [15:0] ret, input logic [15:0] seg);
    chk(16'(pq.size()), 16'h0002);
    if (pq.size() == 2) begin
      chk(pq[0], ret);
      chk(pq[1], seg);
    end
    pq.delete();
  endtask
  task automatic trap_case(input spcu_op_type op, input logic [7:0] arg, input logic [2:0] c);
    int t;
    t = trap_n;
    cmd(op, arg);
    // The trap pulse stands in the same cycle that busy falls and is counted at the next edge, so let one edge pass.
    @(posedge i_clk);
    #1;
    chk(16'(trap_n - t), 16'h0001);
    chk({13'h0, o_trap_cause}, {13'h0, c});
    chk(16'(pq.size()), 16'h0000);
    rd(SPCU_REG_PC, 16'h1020);
  endtask
  task automatic t_load();
    cmd(SPCU_OP_LOAD, 8'h01);
    chk({15'h0, o_priv}, 16'h0000);
    cmd(SPCU_OP_LOAD, 8'h04);
    chk({15'h0, o_priv}, 16'h0001);
    rd(SPCU_REG_BASE, 16'h3000);
    cmd(SPCU_OP_LOAD, 8'h01);
    rd(SPCU_REG_BASE, 16'h1000);
    rd(SPCU_REG_LIMIT, 16'h100f);
    rd(SPCU_REG_SEG, 16'h0001);
  endtask
  task automatic t_local();
    wr(SPCU_REG_PCREL, 16'h0005);
    rd(SPCU_REG_PC, 16'h1005);
    cmd(SPCU_OP_CALL, 8'h01);
    pushed(16'h0006, 16'h0001);
    rd(SPCU_REG_PC, 16'h1020);
    cmd(SPCU_OP_CALL, 8'h01);
    pushed(16'h0021, 16'h0001);
    rd(SPCU_REG_PC, 16'h1020);
  endtask
  task automatic t_external();
    int t;
    t = trace_n;
    i_slow <= 1'b1;
    cmd(SPCU_OP_CALL, 8'h02);
    i_slow <= 1'b0;
    pushed(16'h0021, 16'h0001);
    rd(SPCU_REG_BASE, 16'h2000);
    rd(SPCU_REG_LIMIT, 16'h200f);
    rd(SPCU_REG_PC, 16'h2030);
    rd(SPCU_REG_SEG, 16'h0002);
    chk(16'(trace_n - t), 16'h0001);
  endtask
  task automatic t_exit();
    int p;
    p = pop_n;
    @(posedge i_clk);
    i_stack_top <= 16'h0001;
    i_stack_next <= 16'h0021;
    cmd(SPCU_OP_EXIT, 8'h00);
    chk(16'(pop_n - p), 16'h0001);
    rd(SPCU_REG_BASE, 16'h1000);
    rd(SPCU_REG_PC, 16'h1021);
  endtask
  task automatic t_stack_label();
    int t;
    t = trace_n;
    @(posedge i_clk);
    i_stack_top <= 16'h0050;
    cmd(SPCU_OP_CALL, 8'h00);
    pushed(16'h0022, 16'h0001);
    rd(SPCU_REG_PC, 16'h1050);
    chk(16'(trace_n - t), 16'h0000);
    @(posedge i_clk);
    i_stack_top <= 16'h8200;
    cmd(SPCU_OP_CALL, 8'h00);
    pushed(16'h0051, 16'h0001);
    rd(SPCU_REG_PC, 16'h2000);
    chk(16'(trace_n - t), 16'h0001);
  endtask
  task automatic t_priv();
    cmd(SPCU_OP_LOAD, 8'h04);
    @(posedge i_clk);
    i_stack_top <= 16'h8202;
    cmd(SPCU_OP_CALL, 8'h00);
    pushed(16'h0001, 16'h0004);
    rd(SPCU_REG_PC, 16'h2040);
    chk({15'h0, o_priv}, 16'h0000);
  endtask
  initial begin
    for (int i = 0; i < 18; i++) spcu_mem_model_inst.mem[img[i][31:16]] = img[i][15:0];
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    chk({14'h0, o_priv, o_busy}, 16'h0002);
    rd(SPCU_REG_CMD, 16'h0010);
    t_load();
    t_local();
    trap_case(SPCU_OP_CALL, 8'h05, 3'h1);
    trap_case(SPCU_OP_LOAD, 8'h00, 3'h4);
    trap_case(SPCU_OP_CALL, 8'h03, 3'h3);
    trap_case(SPCU_OP_CALL, 8'h04, 3'h2);
    t_external();
    t_exit();
    t_stack_label();
    t_priv();
    give_verdict();
  end
endmodule // segmented_procedure_call_unit_tb_top
`default_nettype wire
